// file: common/iier_pkg.sv
package iier_pkg;
   // ==========================================================
   // Register map (word offsets as byte addresses)
   localparam logic [7:0] IIER_REG_CTRL   = 8'h00;
   localparam logic [7:0] IIER_REG_POS    = 8'h04;
   localparam logic [7:0] IIER_REG_OCC    = 8'h08;
   localparam logic [7:0] IIER_REG_LUX    = 8'h0c;
   localparam logic [7:0] IIER_REG_HYST   = 8'h10;
   localparam logic [7:0] IIER_REG_STAT   = 8'h14;
   // CTRL bit positions
   localparam int IIER_EN_POS   = 0;
   localparam int IIER_EN_OCC   = 1;
   localparam int IIER_EN_VAC   = 2;
   localparam int IIER_EN_REP   = 3;
   localparam int IIER_EN_MOV   = 4;
   localparam int IIER_EN_NOMOV = 5;
   localparam int IIER_EN_LUX   = 6;
   // Timing: 1 ms tick at 100 MHz, dead time in 50 ms steps
   localparam int IIER_CLK_MHZ    = 100;
   localparam int IIER_TICK_US    = 1000;
   localparam int IIER_TICK_CYC   = IIER_CLK_MHZ * IIER_TICK_US;
   localparam int IIER_MS_PER_S   = 1000;
   localparam int IIER_DEAD_STEP  = 50;
   localparam int IIER_HOLD_STEP  = 10;
   localparam int IIER_HYST_MAX   = 25;
   localparam int IIER_PCT        = 100;
   // Report kinds
   typedef enum logic [2:0] {
      IIER_K_POS   = 3'h0,
      IIER_K_OCC   = 3'h1,
      IIER_K_VAC   = 3'h2,
      IIER_K_MOV   = 3'h3,
      IIER_K_NOMOV = 3'h4,
      IIER_K_LUX   = 3'h5
   } iier_kind_t;
   // Outgoing report
   typedef struct packed {
      logic       valid;
      iier_kind_t kind;
      logic [15:0] value;
   } iier_rep_t;
   // Per-channel timers
   typedef struct packed {
      logic        pend;
      logic [15:0] dead;
      logic [17:0] rep;
   } iier_chan_t;
endpackage

// file: design/iier_top.sv
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
module iier_top
   import iier_pkg::*;
#(
   parameter int TICK_CYC = IIER_TICK_CYC,
   parameter int N_OCC    = 4
)(
   input  wire logic             CLK_I,
   input  wire logic             RESETN_I,
   input  wire logic [7:0]       ADDR_I,
   input  wire logic [31:0]      WDATA_I,
   input  wire logic             WR_I,
   input  wire logic             RD_I,
   output      logic [31:0]      RDATA_O,
   input  wire logic [7:0]       POS_I,
   input  wire logic [N_OCC-1:0] OCC_I,
   input  wire logic [N_OCC-1:0] MOV_I,
   input  wire logic [15:0]      LUX_I,
   output      iier_rep_t        REP_O,
   output      logic             ARRAY_ACT_O
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [31:0]  rdata;
      logic [6:0]   en;
      logic [7:0]   pos_rep, pos_dead;
      logic [7:0]   occ_rep, occ_dead, occ_hold;
      logic [7:0]   lux_rep, lux_dead;
      logic [7:0]   hyst_pct, hyst_min;
      logic [16:0]  div;
      logic         tick;
      logic [7:0]   pos_last;
      logic [15:0]  lux_last;
      logic         occ, mov;
      logic [21:0]  hold;
      iier_chan_t   cp, co, cl;
      iier_kind_t   okind;
      iier_rep_t    rep;
      logic         act;
   } iier_st_t;
   iier_st_t q, d;

   // Assertion clock and reset
   default clocking chk_cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESETN_I);

   // Input synchronisers
   logic [7:0]       pos_s1, pos_s2;
   logic [N_OCC-1:0] occ_s1, occ_s2, mov_s1, mov_s2;
   logic [15:0]      lux_s1, lux_s2;
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         {pos_s1, pos_s2, lux_s1, lux_s2} <= '0;
         {occ_s1, occ_s2, mov_s1, mov_s2} <= '0;
      end else begin
         pos_s1 <= POS_I;
         pos_s2 <= pos_s1;
         occ_s1 <= OCC_I;
         occ_s2 <= occ_s1;
         mov_s1 <= MOV_I;
         mov_s2 <= mov_s1;
         lux_s1 <= LUX_I;
         lux_s2 <= lux_s1;
      end
   end

   // Dead time in ms from 50 ms setting
   function automatic logic [15:0] dead_ms(input logic [7:0] s);
      dead_ms = 16'(s * IIER_DEAD_STEP);
   endfunction
   // Repeat interval in ms from seconds setting
   function automatic logic [17:0] rep_ms(input logic [7:0] s);
      rep_ms = 18'(s * IIER_MS_PER_S);
   endfunction

   // Hysteresis band width
   logic [15:0] band, lux_diff;
   logic        occ_any, mov_any, lux_out;
   always_comb begin
      logic [7:0]  pct;
      logic [23:0] w;
      pct = (q.hyst_pct > 8'(IIER_HYST_MAX)) ? 8'(IIER_HYST_MAX)
                                              : q.hyst_pct;
      w = 24'(q.lux_last * pct / IIER_PCT);
      band = (w[15:0] > {8'h00, q.hyst_min}) ? w[15:0]
                                             : {8'h00, q.hyst_min};
      lux_diff = (lux_s2 > q.lux_last) ? lux_s2 - q.lux_last
                                       : q.lux_last - lux_s2;
      lux_out = q.en[IIER_EN_LUX] && (lux_diff > band);
      occ_any = |occ_s2;
      mov_any = |mov_s2;
   end

   // ==========================================================
   // Next state
   always_comb begin
      logic pos_fire, occ_fire, lux_fire;
      pos_fire = 1'b0;
      occ_fire = 1'b0;
      lux_fire = 1'b0;
      d = q;
      d.rep.valid = 1'b0;
      d.act = 1'b0;
      // Common tick divider
      d.tick = 1'b0;
      if (q.div == 17'(TICK_CYC - 1)) begin
         d.div  = '0;
         d.tick = 1'b1;
      end else begin
         d.div = q.div + 17'h1;
      end
      // Register writes
      if (WR_I) begin
         unique case (ADDR_I)
            IIER_REG_CTRL: d.en = WDATA_I[6:0];
            IIER_REG_POS:  {d.pos_dead, d.pos_rep} = WDATA_I[15:0];
            IIER_REG_OCC:  {d.occ_hold, d.occ_dead, d.occ_rep} =
                              WDATA_I[23:0];
            IIER_REG_LUX:  {d.lux_dead, d.lux_rep} = WDATA_I[15:0];
            IIER_REG_HYST: {d.hyst_min, d.hyst_pct} = WDATA_I[15:0];
            default: ;
         endcase
      end
      // Register reads, data in following cycle
      d.rdata = '0;
      if (RD_I) begin
         unique case (ADDR_I)
            IIER_REG_CTRL: d.rdata = {25'h0, q.en};
            IIER_REG_POS:  d.rdata = {16'h0, q.pos_dead, q.pos_rep};
            IIER_REG_OCC:  d.rdata = {8'h0, q.occ_hold, q.occ_dead,
                                      q.occ_rep};
            IIER_REG_LUX:  d.rdata = {16'h0, q.lux_dead, q.lux_rep};
            IIER_REG_HYST: d.rdata = {16'h0, q.hyst_min, q.hyst_pct};
            IIER_REG_STAT: d.rdata = {6'h0, q.mov, q.occ, q.lux_last,
                                      q.pos_last};
            default:       d.rdata = '0;
         endcase
      end

      // Position channel
      if (!q.en[IIER_EN_POS]) begin
         d.cp = '0;
      end else begin
         if (pos_s2 != q.pos_last && !q.cp.pend) begin
            d.pos_last = pos_s2;
            d.cp.pend  = 1'b1;
            d.cp.dead  = dead_ms(q.pos_dead);
         end else if (q.cp.pend && q.tick && q.cp.dead != '0) begin
            d.cp.dead = q.cp.dead - 16'h1;
         end
         if (q.cp.pend && q.cp.dead == '0) begin
            pos_fire  = 1'b1;
            d.cp.pend = 1'b0;
         end
         if (q.tick && q.pos_rep != '0) begin
            if (q.cp.rep >= rep_ms(q.pos_rep) - 18'h1) begin
               d.cp.rep = '0;
               if (!q.cp.pend) begin
                  d.cp.pend = 1'b1;
                  d.cp.dead = dead_ms(q.pos_dead);
               end
            end else begin
               d.cp.rep = q.cp.rep + 18'h1;
            end
         end
         if (pos_fire) d.cp.rep = '0;
      end

      // Occupancy state with hold time
      if (q.tick && q.hold != '0) d.hold = q.hold - 22'h1;
      if (q.hold == '0 && !q.co.pend &&
          (occ_any != q.occ || mov_any != q.mov)) begin
         d.occ  = occ_any;
         d.mov  = mov_any;
         d.hold = 22'(q.occ_hold * IIER_HOLD_STEP * IIER_MS_PER_S);
         if (occ_any != q.occ) begin
            d.okind = occ_any ? IIER_K_OCC : IIER_K_VAC;
         end else begin
            d.okind = mov_any ? IIER_K_MOV : IIER_K_NOMOV;
         end
         d.co.pend = 1'b1;
         d.co.dead = dead_ms(q.occ_dead);
         if (occ_any && !q.occ) d.act = 1'b1;
      end else if (q.co.pend && q.tick && q.co.dead != '0) begin
         d.co.dead = q.co.dead - 16'h1;
      end
      if (q.co.pend && q.co.dead == '0) begin
         d.co.pend = 1'b0;
         unique case (q.okind)
            IIER_K_OCC:   occ_fire = q.en[IIER_EN_OCC];
            IIER_K_VAC:   occ_fire = q.en[IIER_EN_VAC];
            IIER_K_MOV:   occ_fire = q.en[IIER_EN_MOV];
            IIER_K_NOMOV: occ_fire = q.en[IIER_EN_NOMOV];
            default:      occ_fire = 1'b0;
         endcase
      end
      // Occupancy repeat
      if (!q.en[IIER_EN_REP] || q.occ_rep == '0) begin
         d.co.rep = '0;
      end else if (q.tick) begin
         if (q.co.rep >= rep_ms(q.occ_rep) - 18'h1) begin
            d.co.rep = '0;
            if (!q.co.pend && !d.co.pend) begin
               d.co.pend = 1'b1;
               d.co.dead = dead_ms(q.occ_dead);
            end
         end else begin
            d.co.rep = q.co.rep + 18'h1;
         end
      end

      // Light channel
      if (!q.en[IIER_EN_LUX]) begin
         d.cl = '0;
      end else begin
         if (lux_out && !q.cl.pend) begin
            d.lux_last = lux_s2;
            d.cl.pend  = 1'b1;
            d.cl.dead  = dead_ms(q.lux_dead);
         end else if (q.cl.pend && q.tick && q.cl.dead != '0) begin
            d.cl.dead = q.cl.dead - 16'h1;
         end
         if (q.cl.pend && q.cl.dead == '0) begin
            lux_fire  = 1'b1;
            d.cl.pend = 1'b0;
         end
         if (q.tick && q.lux_rep != '0) begin
            if (q.cl.rep >= rep_ms(q.lux_rep) - 18'h1) begin
               d.cl.rep = '0;
               if (!q.cl.pend && !lux_out) begin
                  d.cl.pend = 1'b1;
                  d.cl.dead = dead_ms(q.lux_dead);
               end
            end else begin
               d.cl.rep = q.cl.rep + 18'h1;
            end
         end
         if (lux_fire) d.cl.rep = '0;
      end

      // Report output, priority position, occupancy, light
      if (pos_fire) begin
         d.rep = '{valid: 1'b1, kind: IIER_K_POS,
                   value: {8'h00, q.pos_last}};
      end else if (occ_fire) begin
         d.rep = '{valid: 1'b1, kind: q.okind,
                   value: {14'h0, q.mov, q.occ}};
      end else if (lux_fire) begin
         d.rep = '{valid: 1'b1, kind: IIER_K_LUX, value: q.lux_last};
      end else if (pos_fire || occ_fire || lux_fire) begin
         d.rep = q.rep;
      end
      // Lost collisions stay pending one more cycle
      if (pos_fire && occ_fire) d.co.pend = 1'b1;
      if ((pos_fire || occ_fire) && lux_fire) d.cl.pend = 1'b1;
   end

   // ==========================================================
   // State register
   always_ff @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign RDATA_O     = q.rdata;
   assign REP_O       = q.rep;
   assign ARRAY_ACT_O = q.act;

   // ==========================================================
   // Checks
   // Send steps: armed with no dead time left, then sent
   sequence pos_arm_s;
      $rose(q.cp.pend) && q.cp.dead == '0 && q.en[IIER_EN_POS];
   endsequence
   sequence occ_arm_s;
      $rose(q.co.pend) && q.co.dead == '0 && q.en[IIER_EN_OCC]
         && q.okind == IIER_K_OCC;
   endsequence
   // A member goes occupied while the state may change
   sequence member_new_s;
      occ_any && !q.occ && q.hold == '0 && !q.co.pend;
   endsequence

   // Reports only for enabled kinds
   occ_gate_a: assert property (
      REP_O.valid && REP_O.kind == IIER_K_OCC |-> $past(q.en[IIER_EN_OCC]))
      else $error("occupied report while disabled");
   vac_gate_a: assert property (
      REP_O.valid && REP_O.kind == IIER_K_VAC |-> $past(q.en[IIER_EN_VAC]))
      else $error("vacant report while disabled");
   mov_gate_a: assert property (
      REP_O.valid && REP_O.kind == IIER_K_MOV |-> $past(q.en[IIER_EN_MOV]))
      else $error("movement report while disabled");
   nomov_gate_a: assert property (
      REP_O.valid && REP_O.kind == IIER_K_NOMOV
         |-> $past(q.en[IIER_EN_NOMOV]))
      else $error("no movement report while disabled");
   pos_gate_a: assert property (
      REP_O.valid && REP_O.kind == IIER_K_POS |-> $past(q.en[IIER_EN_POS]))
      else $error("position report while disabled");
   lux_gate_a: assert property (
      REP_O.valid && REP_O.kind == IIER_K_LUX |-> $past(q.en[IIER_EN_LUX]))
      else $error("light report while disabled");

   // Dead time: nothing early, nothing lost
   pos_clear_a: assert property (
      !q.en[IIER_EN_POS] |=> !q.cp.pend)
      else $error("position pending while disabled");
   dead_wait_a: assert property (
      $rose(q.cp.pend) && q.cp.dead != '0 |=> (!REP_O.valid
         || REP_O.kind != IIER_K_POS))
      else $error("position sent before dead time");
   pos_send_a: assert property (
      pos_arm_s |=> (REP_O.valid && REP_O.kind == IIER_K_POS))
      else $error("position not sent after dead time");
   occ_send_a: assert property (
      occ_arm_s |-> ##[1:3] (REP_O.valid && REP_O.kind == IIER_K_OCC))
      else $error("occupied not sent after dead time");

   // Hold time keeps the whole occupancy state
   hold_keep_a: assert property (
      q.hold != '0 |=> (q.occ == $past(q.occ) && q.mov == $past(q.mov)))
      else $error("occupancy changed inside hold");

   // Array action follows the array going from vacant to occupied
   array_act_a: assert property (
      ARRAY_ACT_O |-> q.occ && $past(q.hold) == '0)
      else $error("array action without new occupancy");
   array_fire_a: assert property (
      member_new_s |=> ARRAY_ACT_O)
      else $error("array action missing");

   // Light level taken only outside the band
   lux_band_a: assert property (
      $changed(q.lux_last) |-> $past(lux_out))
      else $error("light level taken inside band");

   // Common tick is a single cycle pulse
   tick_space_a: assert property (
      q.tick |=> !q.tick)
      else $error("tick longer than one cycle");
endmodule

// file: tb/iier_ctl_model.sv
`timescale 1ns/100ps
// ==========================================================
// Controller side: takes every report off the block
module iier_ctl_model
   import iier_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire iier_rep_t   rep_i,
   input  wire logic        act_i,
   output      logic [15:0] cnt_o,
   output      iier_rep_t   last_o,
   output      logic [15:0] act_cnt_o
);
   // Count reports and actions, latch the latest report
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_o     <= 16'h0000;
         last_o    <= '0;
         act_cnt_o <= 16'h0000;
      end else begin
         if (rep_i.valid) begin
            cnt_o  <= cnt_o + 16'h0001;
            last_o <= rep_i;
         end
         if (act_i) begin
            act_cnt_o <= act_cnt_o + 16'h0001;
         end
      end
   end
endmodule

// file: tb/tb_iier_top.sv
`timescale 1ns/100ps
module tb_iier_top;
   import iier_pkg::*;
   // ==========================================================
   // Signals, rows and instances
   typedef struct {
      logic [7:0]  ctrl;
      bit          lux;
      logic [15:0] val;
      bit          want;
      iier_kind_t  kind;
   } iier_row_t;
   logic        CLK_I, RESETN_I, WR_I, RD_I, ARRAY_ACT_O;
   logic [7:0]  ADDR_I, POS_I;
   logic [31:0] WDATA_I, RDATA_O, rd_d;
   logic [3:0]  OCC_I, MOV_I;
   logic [15:0] LUX_I, cnt, act_cnt;
   iier_rep_t   REP_O, last;
   int          fails = 0;
   int          comparisons = 0;
   int          t;
   iier_row_t   rows[6] = '{
      '{8'h01, 0, 16'h0033, 1, IIER_K_POS},
      '{8'h00, 0, 16'h0044, 0, IIER_K_POS},
      '{8'h40, 1, 16'h03e8, 1, IIER_K_LUX},
      '{8'h40, 1, 16'h0418, 0, IIER_K_LUX},
      '{8'h40, 1, 16'h04b0, 1, IIER_K_LUX},
      '{8'h00, 1, 16'h0100, 0, IIER_K_LUX}};

   iier_top #(.TICK_CYC(2), .N_OCC(4)) dut (.CLK_I(CLK_I),
      .RESETN_I(RESETN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
      .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .POS_I(POS_I),
      .OCC_I(OCC_I), .MOV_I(MOV_I), .LUX_I(LUX_I), .REP_O(REP_O),
      .ARRAY_ACT_O(ARRAY_ACT_O));
   iier_ctl_model model (.clk_i(CLK_I), .rst_n_i(RESETN_I),
      .rep_i(REP_O), .act_i(ARRAY_ACT_O), .cnt_o(cnt), .last_o(last),
      .act_cnt_o(act_cnt));

   // Clock, 10 ns period
   initial begin
      CLK_I = 1'b0;
      forever #5 CLK_I = ~CLK_I;
   end

   // ==========================================================
   // Bus, wait and compare tasks
   task results();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask
   task chk_rep(input iier_kind_t k, input logic [15:0] v);
      chk("report kind", {29'h0, k}, {29'h0, last.kind});
      chk("report value", {16'h0, v}, {16'h0, last.value});
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_I);
      ADDR_I  <= a;
      WDATA_I <= d;
      WR_I    <= 1'b1;
      @(posedge CLK_I);
      WR_I <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge CLK_I);
      ADDR_I <= a;
      RD_I   <= 1'b1;
      @(posedge CLK_I);
      RD_I <= 1'b0;
      #1 d = RDATA_O;
   endtask
   // Cycles until the next report, -1 if none within hi
   task await(input int hi, input bit need, output int w);
      logic [15:0] c0;
      c0 = cnt;
      w = -1;
      for (int i = 0; i < hi && w < 0; i++) begin
         @(posedge CLK_I);
         #1;
         if (cnt !== c0) w = i;
      end
      if (need && w < 0) begin
         fails++;
         $display("wrong value report expected pulse seen none");
         results();
      end
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      RESETN_I = 1'b0;
      WR_I = 1'b0;
      RD_I = 1'b0;
      ADDR_I = 8'h00;
      WDATA_I = 32'h0;
      POS_I = 8'h00;
      OCC_I = 4'h0;
      MOV_I = 4'h0;
      LUX_I = 16'h0;
      repeat (5) @(posedge CLK_I);
      #1;
      chk("reset report", 32'h0, {12'h0, REP_O});
      chk("reset action", 32'h0, {31'h0, ARRAY_ACT_O});
      @(posedge CLK_I);
      RESETN_I <= 1'b1;
      // Band 10 percent, at least 20 lux
      wr(IIER_REG_HYST, 32'h0000_140a);
      rd(IIER_REG_HYST, rd_d);
      chk("hyst readback", 32'h0000_140a, rd_d);
      foreach (rows[i]) begin
         wr(IIER_REG_CTRL, {24'h0, rows[i].ctrl});
         repeat (20) @(posedge CLK_I);
         if (rows[i].lux) LUX_I <= rows[i].val;
         else POS_I <= rows[i].val[7:0];
         await(60, 0, t);
         chk("event", {31'h0, rows[i].want}, {31'h0, t >= 0});
         if (rows[i].want) chk_rep(rows[i].kind, rows[i].val);
      end
      rd(8'h20, rd_d);
      chk("unmapped read", 32'h0, rd_d);
      rd(IIER_REG_STAT, rd_d);
      chk("status", 32'h0004_b033, rd_d);
      // Enabling reports the position moved while disabled
      wr(IIER_REG_CTRL, 32'h1);
      await(40, 1, t);
      chk_rep(IIER_K_POS, 16'h0044);
      // Dead time two steps, 200 cycles
      wr(IIER_REG_POS, 32'h0000_0200);
      repeat (20) @(posedge CLK_I);
      POS_I <= 8'h5a;
      await(260, 1, t);
      chk("dead time", 32'h1, {31'h0, t >= 190 && t <= 215});
      chk_rep(IIER_K_POS, 16'h005a);
      // Repeat every second, 2000 cycles
      wr(IIER_REG_POS, 32'h0000_0001);
      POS_I <= 8'h21;
      await(40, 1, t);
      await(2100, 1, t);
      chk("repeat", 32'h1, {31'h0, t >= 1985 && t <= 2015});
      chk_rep(IIER_K_POS, 16'h0021);
      wr(IIER_REG_CTRL, 32'h0);
      await(2100, 0, t);
      chk("repeat off", 32'h0, {31'h0, t >= 0});
      // Occupancy, hold one step of 20000 cycles
      wr(IIER_REG_OCC, 32'h0001_0000);
      wr(IIER_REG_CTRL, 32'h6);
      repeat (20) @(posedge CLK_I);
      OCC_I <= 4'h4;
      await(40, 1, t);
      chk_rep(IIER_K_OCC, 16'h0001);
      repeat (5) @(posedge CLK_I);
      chk("array action", 32'h1, {16'h0, act_cnt});
      OCC_I <= 4'h0;
      await(15000, 0, t);
      chk("hold", 32'h0, {31'h0, t >= 0});
      await(6000, 1, t);
      chk_rep(IIER_K_VAC, 16'h0000);
      // Occupied masked, hold zero from here on
      wr(IIER_REG_CTRL, 32'h4);
      wr(IIER_REG_OCC, 32'h0);
      OCC_I <= 4'h1;
      MOV_I <= 4'h1;
      await(21000, 0, t);
      chk("masked", 32'h0, {31'h0, t >= 0});
      chk("second action", 32'h2, {16'h0, act_cnt});
      // Movement alone, no-movement masked
      wr(IIER_REG_CTRL, 32'h10);
      MOV_I <= 4'h0;
      await(40, 0, t);
      chk("no movement masked", 32'h0, {31'h0, t >= 0});
      MOV_I <= 4'h1;
      await(40, 1, t);
      chk_rep(IIER_K_MOV, 16'h0003);
      // Occupancy repeat every second, 2000 cycles
      wr(IIER_REG_OCC, 32'h0000_0001);
      wr(IIER_REG_CTRL, 32'h18);
      await(2100, 1, t);
      chk("occ repeat", 32'h1, {31'h0, t >= 1990 && t <= 2010});
      chk_rep(IIER_K_MOV, 16'h0003);
      // Reset in mid-run clears outputs and registers
      RESETN_I <= 1'b0;
      repeat (2) @(posedge CLK_I);
      #1;
      chk("reset report", 32'h0, {12'h0, REP_O});
      @(posedge CLK_I);
      RESETN_I <= 1'b1;
      rd(IIER_REG_CTRL, rd_d);
      chk("reset control", 32'h0, rd_d);
      results();
   end
endmodule
